/* verilog/rpf_pkg.sv */
/*
  Constants for the run permit and frequency reference block: register map,
  field positions, reset values, setting codes and timing.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package rpf_pkg;
  // register byte offsets
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STEP   = 8'h04;
  localparam logic [7:0]  ADDR_KEYPAD = 8'h08;
  localparam logic [7:0]  ADDR_COMM   = 8'h0C;
  localparam logic [7:0]  ADDR_SETPT  = 8'h10;
  localparam logic [7:0]  ADDR_ACCEL  = 8'h14;
  localparam logic [7:0]  ADDR_STATUS = 8'h18;
  localparam logic [7:0]  ADDR_FREQ   = 8'h1C;
  localparam logic [7:0]  ADDR_CMD    = 8'h20;
  // control register fields (lsb positions, 2 bits except F_SRC 3 bits, F_SRUN and F_SREV 1 bit)
  localparam int          F_DIR       = 0;
  localparam int          F_LOCK      = 2;
  localparam int          F_LOSS      = 4;
  localparam int          F_UPDN      = 6;
  localparam int          F_SAVE      = 8;
  localparam int          F_INIT      = 10;
  localparam int          F_SRC       = 12;
  localparam int          F_SRUN      = 15;
  localparam int          F_SREV      = 16;
  localparam int          CTRL_W      = 17;
  localparam int          F_RSTKEY    = 0;
  localparam logic [16:0] CTRL_RST    = 17'h01004;
  // frequencies in 0.01 Hz units
  localparam logic [15:0] FREQ_MAX    = 16'hEA60;
  localparam logic [15:0] FREQ_DEF    = 16'h1770;
  localparam logic [15:0] STEP_MIN    = 16'h0001;
  localparam logic [15:0] STEP_MAX    = 16'h03E8;
  localparam logic [15:0] ACCEL_DEF   = 16'h0001;
  localparam logic [15:0] KEY_STEP    = 16'h0001;
  // setting codes
  localparam logic [1:0]  DIR_INH_REV = 2'h1;
  localparam logic [1:0]  DIR_INH_FWD = 2'h2;
  localparam logic [1:0]  LOSS_DECEL  = 2'h0;
  localparam logic [1:0]  LOSS_COAST  = 2'h1;
  localparam logic [1:0]  UD_KEYPAD   = 2'h0;
  localparam logic [1:0]  UD_ACCEL    = 2'h1;
  localparam logic [1:0]  UD_CONST    = 2'h2;
  localparam logic [1:0]  UD_PULSE    = 2'h3;
  localparam logic [1:0]  SAVE_KEYPAD = 2'h1;
  localparam logic [1:0]  SAVE_COMM   = 2'h2;
  localparam logic [1:0]  INIT_CUR    = 2'h0;
  localparam logic [1:0]  INIT_ZERO   = 2'h1;
  localparam logic [2:0]  SRC_TERM_A  = 3'h1;
  localparam logic [2:0]  SRC_TERM_B  = 3'h2;
  localparam logic [2:0]  SRC_COMM_A  = 3'h3;
  localparam logic [2:0]  SRC_COMM_B  = 3'h4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // timing
  localparam int          CLK_MHZ     = 200;
  localparam int          STEP_INT_US = 2000;
  localparam int          TICK_CYC    = STEP_INT_US * CLK_MHZ;
  localparam int          TICK_W      = 19;
  localparam int          N_PINS      = 8;
  typedef enum logic [1:0] {
    RPF_SETTLE1 = 2'b00,
    RPF_SETTLE2 = 2'b01,
    RPF_EVAL    = 2'b11,
    RPF_ACTIVE  = 2'b10
  } rpf_state_e;
endpackage

/* verilog/rpf_run_permit.sv */
/*
  Run permit, direction inhibit, start lockout, source change handling and
  frequency reference (up/down, keypad and comm commands, initial frequency).
  Assumes pins are asynchronous to sys_clk and AXI4-Lite on sys_clk.
*/
`timescale 1ns/1ps
module rpf_run_permit #(
  parameter int TICK_CYCLES = rpf_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // axi4-lite slave
  input  wire logic [rpf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [rpf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // asynchronous pins
  input  wire logic                       run_input_one,
  input  wire logic                       run_input_two,
  input  wire logic                       up_input,
  input  wire logic                       down_input,
  input  wire logic                       key_up,
  input  wire logic                       key_down,
  input  wire logic                       key_reset,
  input  wire logic                       current_loop_input,
  // drive outputs
  output logic                            run_out,
  output logic                            reverse_out,
  output logic [15:0]                     freq_out,
  output logic                            coast_out,
  output logic                            decel_zero_out,
  output logic                            analog_loss_warning,
  output logic                            warning_blink
);
  import rpf_pkg::*;

  function automatic logic [15:0] clamp_f(input logic [15:0] v);
    clamp_f = (v > FREQ_MAX) ? FREQ_MAX : v;
  endfunction
  function automatic logic [15:0] clamp_s(input logic [15:0] v);
    clamp_s = (v < STEP_MIN) ? STEP_MIN : ((v > STEP_MAX) ? STEP_MAX : v);
  endfunction
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    wmerge = r;
  endfunction
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STEP) || (a == ADDR_KEYPAD) || (a == ADDR_COMM)
          || (a == ADDR_SETPT) || (a == ADDR_ACCEL) || (a == ADDR_STATUS)
          || (a == ADDR_FREQ) || (a == ADDR_CMD);
  endfunction
  function automatic logic is_term(input logic [2:0] s);
    is_term = (s == SRC_TERM_A) || (s == SRC_TERM_B);
  endfunction
  function automatic logic dir_ok(input logic rev, input logic [1:0] inh);
    dir_ok = !(rev && inh == DIR_INH_REV) && !(!rev && inh == DIR_INH_FWD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam logic [N_PINS-1:0] PIN_IDLE = 8'h80;  // loop current present, no false loss
  logic [N_PINS-1:0] pin_raw, sync1_q, sync2_q, prev_q;
  assign pin_raw = {current_loop_input, key_reset, key_down, key_up,
                    down_input, up_input, run_input_two, run_input_one};
  generate
    for (genvar i = 0; i < N_PINS; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_q[i] <= PIN_IDLE[i];
          sync2_q[i] <= PIN_IDLE[i];
          prev_q[i]  <= PIN_IDLE[i];
        end else begin
          sync1_q[i] <= pin_raw[i];
          sync2_q[i] <= sync1_q[i];
          prev_q[i]  <= sync2_q[i];
        end
      end
    end
  endgenerate
  logic in1, in2, up_s, dn_s, lost, up_rise, dn_rise, kup_rise, kdn_rise;
  logic term_run, term_rev;
  assign in1      = sync2_q[0];
  assign in2      = sync2_q[1];
  assign up_s     = sync2_q[2];
  assign dn_s     = sync2_q[3];
  assign lost     = !sync2_q[7];
  assign up_rise  = sync2_q[2] & ~prev_q[2];
  assign dn_rise  = sync2_q[3] & ~prev_q[3];
  assign kup_rise = sync2_q[4] & ~prev_q[4];
  assign kdn_rise = sync2_q[5] & ~prev_q[5];
  assign term_run = in1 | in2;
  assign term_rev = in2 & ~in1;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q, w_have_q, wr_fire, rd_fire;
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       step_q, keypad_q, comm_q, setpt_q, accel_q, freq_q;
  logic [31:0]       status_w, ctrl_m, step_m, setpt_m, accel_m, keypad_m, comm_m;
  logic              rst_key_pulse;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign rst_key_pulse = (wr_fire && awaddr_q == ADDR_CMD && wstrb_q[0] && wdata_q[F_RSTKEY])
                      || (sync2_q[6] && !prev_q[6]);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_CTRL:   s_axi_rdata <= {15'h0000, ctrl_q};
        ADDR_STEP:   s_axi_rdata <= {16'h0000, step_q};
        ADDR_KEYPAD: s_axi_rdata <= {16'h0000, keypad_q};
        ADDR_COMM:   s_axi_rdata <= {16'h0000, comm_q};
        ADDR_SETPT:  s_axi_rdata <= {16'h0000, setpt_q};
        ADDR_ACCEL:  s_axi_rdata <= {16'h0000, accel_q};
        ADDR_STATUS: s_axi_rdata <= status_w;
        ADDR_FREQ:   s_axi_rdata <= {16'h0000, freq_q};
        default:     s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings registers
  logic stop_evt;
  assign ctrl_m   = wmerge({15'h0000, ctrl_q}, wdata_q, wstrb_q);
  assign step_m   = wmerge({16'h0000, step_q}, wdata_q, wstrb_q);
  assign setpt_m  = wmerge({16'h0000, setpt_q}, wdata_q, wstrb_q);
  assign accel_m  = wmerge({16'h0000, accel_q}, wdata_q, wstrb_q);
  assign keypad_m = wmerge({16'h0000, keypad_q}, wdata_q, wstrb_q);
  assign comm_m   = wmerge({16'h0000, comm_q}, wdata_q, wstrb_q);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q  <= CTRL_RST;
      step_q  <= STEP_MIN;
      setpt_q <= FREQ_DEF;
      accel_q <= ACCEL_DEF;
    end else if (wr_fire) begin
      case (awaddr_q)
        ADDR_CTRL:  ctrl_q  <= ctrl_m[CTRL_W-1:0];
        ADDR_STEP:  step_q  <= clamp_s(step_m[15:0]);
        ADDR_SETPT: setpt_q <= clamp_f(setpt_m[15:0]);
        ADDR_ACCEL: accel_q <= clamp_s(accel_m[15:0]);
        default: ;
      endcase
    end
  end
  logic [1:0] dir_set, lock_set, loss_set, ud_set, save_set, init_set;
  logic [2:0] src;
  assign dir_set  = ctrl_q[F_DIR +: 2];
  assign lock_set = ctrl_q[F_LOCK +: 2];
  assign loss_set = ctrl_q[F_LOSS +: 2];
  assign ud_set   = ctrl_q[F_UPDN +: 2];
  assign save_set = ctrl_q[F_SAVE +: 2];
  assign init_set = ctrl_q[F_INIT +: 2];
  assign src      = ctrl_q[F_SRC +: 3];

  // keypad and comm commands; with SAVE_KEYPAD or SAVE_COMM the unsaved one reverts to FREQ_DEF at stop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      keypad_q <= FREQ_DEF;
      comm_q   <= FREQ_DEF;
    end else begin
      if (wr_fire && awaddr_q == ADDR_KEYPAD) begin
        keypad_q <= clamp_f(keypad_m[15:0]);
      end else if (stop_evt && save_set == SAVE_COMM) begin
        keypad_q <= FREQ_DEF;
      end
      if (wr_fire && awaddr_q == ADDR_COMM) begin
        comm_q <= clamp_f(comm_m[15:0]);
      end else if (stop_evt && save_set == SAVE_KEYPAD) begin
        comm_q <= FREQ_DEF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequence and lockout
  rpf_state_e state_q;
  logic       lock_q, hold_q, run_q, rev_q, run_d, rev_d, coast, src_enter, mismatch;
  logic [2:0] src_prev_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RPF_SETTLE1;
    end else begin
      case (state_q)
        RPF_SETTLE1: state_q <= RPF_SETTLE2;
        RPF_SETTLE2: state_q <= RPF_EVAL;
        RPF_EVAL:    state_q <= RPF_ACTIVE;
        RPF_ACTIVE:  state_q <= RPF_ACTIVE;
        default:     state_q <= RPF_SETTLE1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= 1'b0;
    end else if (state_q == RPF_EVAL) begin
      lock_q <= is_term(src) && term_run && lock_set[0];
    end else if (!term_run || !is_term(src)) begin
      lock_q <= 1'b0;
    end
  end

  assign src_enter = is_term(src) && !is_term(src_prev_q);
  assign mismatch  = term_run != run_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_prev_q <= SRC_TERM_A;
      hold_q     <= 1'b0;
    end else begin
      src_prev_q <= src;
      if (src_enter && mismatch && !lock_set[1]) begin
        hold_q <= 1'b1;
      end else if (!mismatch || !is_term(src)) begin
        hold_q <= 1'b0;
      end
    end
  end

  assign coast = lost && loss_set == LOSS_COAST;
  always_comb begin
    run_d = run_q;
    rev_d = rev_q;
    if (state_q != RPF_ACTIVE || coast) begin
      run_d = 1'b0;
    end else if (is_term(src)) begin
      if (lock_q) begin
        run_d = 1'b0;
      end else if (hold_q || (src_enter && mismatch && !lock_set[1])) begin
        run_d = run_q;
      end else begin
        run_d = term_run && dir_ok(term_rev, dir_set);
        rev_d = term_rev;
      end
    end else begin
      run_d = ctrl_q[F_SRUN] && dir_ok(ctrl_q[F_SREV], dir_set);
      rev_d = ctrl_q[F_SREV];
    end
  end
  assign stop_evt = run_q && !run_d;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      run_q <= run_d;
      rev_q <= rev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loss warning
  logic warn_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      warn_q <= 1'b0;
    end else if (coast) begin
      warn_q <= 1'b1;
    end else if (rst_key_pulse) begin
      warn_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // up/down frequency adjustment
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick, inc, dec;
  logic [15:0]       amt, init_f, cur_cmd;
  assign tick = tick_cnt_q == TICK_W'(TICK_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
    end
  end

  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    amt = step_q;
    case (ud_set)
      UD_KEYPAD: begin
        inc = kup_rise && run_q;
        dec = kdn_rise && run_q;
        amt = KEY_STEP;
      end
      UD_ACCEL: begin
        inc = up_s && tick && run_q;
        dec = dn_s && tick && run_q;
        amt = accel_q;
      end
      UD_CONST: begin
        inc = up_s && tick;
        dec = dn_s && tick;
      end
      UD_PULSE: begin
        inc = up_rise;
        dec = dn_rise;
      end
      default: ;
    endcase
  end

  assign cur_cmd = (src == SRC_COMM_A || src == SRC_COMM_B) ? comm_q : keypad_q;
  assign init_f  = (init_set == INIT_CUR) ? cur_cmd :
                   (init_set == INIT_ZERO) ? 16'h0000 : setpt_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_q <= FREQ_DEF;
    end else if (stop_evt) begin
      freq_q <= init_f;
    end else if (inc && !dec) begin
      freq_q <= clamp_f((FREQ_MAX - freq_q < amt) ? FREQ_MAX : freq_q + amt);
    end else if (dec && !inc) begin
      freq_q <= (freq_q < amt) ? 16'h0000 : freq_q - amt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_out       <= '0;
      coast_out      <= 1'b0;
      decel_zero_out <= 1'b0;
      warning_blink  <= 1'b0;
    end else begin
      decel_zero_out <= lost && loss_set == LOSS_DECEL;
      freq_out       <= (lost && loss_set == LOSS_DECEL) ? 16'h0000 : freq_q;
      coast_out      <= coast;
      warning_blink  <= (warn_q || coast) && lost;
    end
  end
  assign run_out             = run_q;
  assign reverse_out         = rev_q;
  assign analog_loss_warning = warn_q;
  assign status_w = {24'h000000, decel_zero_out, coast_out, hold_q, lock_q,
                     warning_blink, warn_q, rev_q, run_q};

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_dir;
    (run_q && rev_q) |-> $past(dir_set) != DIR_INH_REV;
  endproperty
  a_dir: assert property (p_dir) else $error("reverse run while inhibited");

  property p_lock_set;
    (state_q == RPF_EVAL && is_term(src) && term_run && lock_set[0]) |=> lock_q ##0 !run_q;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lockout not taken");

  property p_no_lock;
    (state_q == RPF_EVAL && !lock_set[0]) |=> !lock_q;
  endproperty
  a_no_lock: assert property (p_no_lock) else $error("lockout taken wrongly");

  property p_lock_run;
    lock_q |-> !run_q throughout (lock_q [*1]);
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("run during lockout");

  property p_keep;
    (state_q == RPF_ACTIVE && src_enter && mismatch && !lock_set[1] && !coast)
      |=> run_q == $past(run_q) && hold_q;
  endproperty
  a_keep: assert property (p_keep) else $error("source change not held");

  property p_follow;
    (state_q == RPF_ACTIVE && src_enter && lock_set[1] && !lock_q && !coast)
      |=> run_q == $past(term_run && dir_ok(term_rev, dir_set));
  endproperty
  a_follow: assert property (p_follow) else $error("terminal state not followed");

  property p_coast;
    coast |=> !run_q && warn_q ##1 coast_out || !lost;
  endproperty
  a_coast: assert property (p_coast) else $error("loss coast missing");

  property p_warn;
    (warn_q && !coast && !rst_key_pulse) |=> warn_q;
  endproperty
  a_warn: assert property (p_warn) else $error("warning cleared without key");

  property p_accel_idle;
    (ud_set == UD_ACCEL && !run_q) |=> freq_q == $past(freq_q);
  endproperty
  a_accel_idle: assert property (p_accel_idle) else $error("freq moved while stopped");

  property p_init_zero;
    (stop_evt && init_set == INIT_ZERO) |=> freq_q == 16'h0000;
  endproperty
  a_init_zero: assert property (p_init_zero) else $error("initial zero not loaded");

  property p_range;
    keypad_q <= FREQ_MAX && comm_q <= FREQ_MAX && setpt_q <= FREQ_MAX && freq_q <= FREQ_MAX;
  endproperty
  a_range: assert property (p_range) else $error("frequency out of range");
endmodule

/* tb/rpf_far_side.sv */
/*
  far side model: terminal run contacts, keypad keys and current loop.
  assumes sys_clk from the bench; pins change just after a rising edge.
*/
`timescale 1ns/1ps
module rpf_far_side (
  // clock and pins
  input  wire logic sys_clk,
  output logic      run_input_one,
  output logic      run_input_two,
  output logic      up_input,
  output logic      down_input,
  output logic      key_up,
  output logic      key_down,
  output logic      key_reset,
  output logic      current_loop_input
);
  initial begin
    {run_input_two, up_input, down_input, key_up, key_down, key_reset} = 6'h00;
    run_input_one      = 1'h1; // contacts already closed at power-up
    current_loop_input = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic set_pin(input int k, input logic v);
    @(posedge sys_clk);
    case (k)
      0: run_input_one <= v;
      2: run_input_two <= v;
      3: up_input <= v;
      default: current_loop_input <= v;
    endcase
  endtask
  task automatic tap(input int k);
    @(posedge sys_clk);
    if (k == 0) up_input <= 1'h1;
    else key_reset <= 1'h1;
    repeat (6) @(posedge sys_clk);
    up_input  <= 1'h0;
    key_reset <= 1'h0;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

/* tb/rpf_run_permit_tb_top.sv */
/*
  bench for the run permit block: axi4-lite tasks and pin scenarios.
  assumes rpf_far_side drives the pins; addresses from rpf_pkg, expected values as literals.
*/
`timescale 1ns/1ps
module rpf_run_permit_tb_top;
  import rpf_pkg::*;
  logic        sys_clk = 1'h0, rst_b = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] freq_out;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        run_out, reverse_out, coast_out, decel_zero_out, analog_loss_warning;
  logic        warning_blink, run_input_one, run_input_two, up_input, down_input;
  logic        key_up, key_down, key_reset, current_loop_input;
  logic [7:0]  ra [6] = '{ADDR_CTRL, ADDR_STEP, ADDR_KEYPAD, ADDR_COMM, ADDR_SETPT, ADDR_ACCEL};
  logic [31:0] rv [6] = '{32'h01004, 32'h1, 32'h1770, 32'h1770, 32'h1770, 32'h1};
  int          num_errors = 0, cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  rpf_run_permit #(.TICK_CYCLES(20)) dut_u (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_input_one, .run_input_two, .up_input,
    .down_input, .key_up, .key_down, .key_reset, .current_loop_input, .run_out, .reverse_out,
    .freq_out, .coast_out, .decel_zero_out, .analog_loss_warning, .warning_blink);
  rpf_far_side far_u (.sys_clk, .run_input_one, .run_input_two, .up_input, .down_input,
    .key_up, .key_down, .key_reset, .current_loop_input);
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task tmo(input int n);
    if (n >= 50) begin
      num_errors++;
      close_out;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    tmo(n);
  endtask
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      rd_q = s_axi_rdata;
      rsp  = s_axi_rresp;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    tmo(n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rd_q, rv[i]);
    end
    rd(8'h40);
    chk(32'(rsp), 32'h2);
    chk(32'(run_out), 32'h0);
    far_u.set_pin(0, 1'h0);
    repeat (8) @(posedge sys_clk);
    far_u.set_pin(0, 1'h1);
    repeat (8) @(posedge sys_clk);
    chk(32'(run_out), 32'h1);
    wr(ADDR_CTRL, 32'h010C4);
    wr(ADDR_STEP, 32'h5);
    far_u.tap(0);
    rd(ADDR_FREQ);
    chk(rd_q, 32'h1775);
    chk(32'(freq_out), 32'h1775);
    wr(ADDR_CTRL, 32'h01084);
    far_u.set_pin(3, 1'h1);
    repeat (39) @(posedge sys_clk);
    far_u.set_pin(3, 1'h0);
    repeat (4) @(posedge sys_clk);
    rd(ADDR_FREQ);
    chk(rd_q, 32'h177F);
    wr(ADDR_KEYPAD, 32'hFFFF);
    rd(ADDR_KEYPAD);
    chk(rd_q, 32'hEA60);
    wr(ADDR_COMM, 32'h1234);
    rd(ADDR_COMM);
    chk(rd_q, 32'h1234);
    wr(ADDR_CTRL, 32'h010C6);
    repeat (8) @(posedge sys_clk);
    chk(32'(run_out), 32'h0);
    rd(ADDR_FREQ);
    chk(rd_q, 32'hEA60);
    wr(ADDR_CTRL, 32'h01014);
    far_u.set_pin(1, 1'h0);
    repeat (8) @(posedge sys_clk);
    chk(32'(coast_out), 32'h1);
    chk(32'(warning_blink), 32'h1);
    far_u.set_pin(1, 1'h1);
    repeat (8) @(posedge sys_clk);
    chk(32'({warning_blink, analog_loss_warning}), 32'h1);
    far_u.tap(1);
    chk(32'(analog_loss_warning), 32'h0);
    wr(ADDR_CTRL, 32'h03014);
    wr(ADDR_CTRL, 32'h01014);
    repeat (8) @(posedge sys_clk);
    chk(32'(run_out), 32'h0);
    wr(ADDR_CTRL, 32'h0301C);
    wr(ADDR_CTRL, 32'h0101C);
    repeat (8) @(posedge sys_clk);
    chk(32'(run_out), 32'h1);
    far_u.set_pin(2, 1'h1);
    far_u.set_pin(0, 1'h0);
    repeat (8) @(posedge sys_clk);
    chk(32'({run_out, reverse_out}), 32'h3);
    wr(ADDR_CTRL, 32'h0100D);
    repeat (8) @(posedge sys_clk);
    chk(32'(run_out), 32'h0);
    far_u.set_pin(1, 1'h0);
    repeat (8) @(posedge sys_clk);
    chk(32'({decel_zero_out, freq_out}), 32'h10000);
    close_out;
  end
endmodule
